// ---- led_limit_pkg.sv ----
// constants, layouts and types for the led current-limit register slice
package led_limit_pkg;

  localparam int ADDR_WIDTH  = 8;
  localparam int DATA_WIDTH  = 32;
  localparam int REG_WIDTH   = 8;
  localparam int CODE_WIDTH  = 10;
  localparam int INDEX_WIDTH = 6;
  localparam int MA_WIDTH    = 11;
  localparam int REG_COUNT   = 5;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_TRANSIENT_LIMIT_CONFIG = 6'h02;
  localparam logic [5:0] IDX_CH4_CURRENT_UPPER      = 6'h03;
  localparam logic [5:0] IDX_CH4_CURRENT_LOWER      = 6'h04;
  localparam logic [5:0] IDX_CH5_CURRENT_UPPER      = 6'h05;
  localparam logic [5:0] IDX_CH5_CURRENT_LOWER      = 6'h06;
  localparam logic [5:0] IDX_CODE_STATUS            = 6'h30;
  localparam logic [5:0] IDX_THRESHOLD_MA           = 6'h31;

  // reset values
  localparam logic [7:0] RST_TRANSIENT_LIMIT_CONFIG = 8'h30;
  localparam logic [7:0] RST_CH4_CURRENT_UPPER      = 8'h00;
  localparam logic [7:0] RST_CH4_CURRENT_LOWER      = 8'h00;
  localparam logic [7:0] RST_CH5_CURRENT_UPPER      = 8'h00;
  localparam logic [7:0] RST_CH5_CURRENT_LOWER      = 8'h00;

  // slot order of the writable registers in the bank
  localparam int SLOT_LIMIT     = 0;
  localparam int SLOT_CH4_UPPER = 1;
  localparam int SLOT_CH4_LOWER = 2;
  localparam int SLOT_CH5_UPPER = 3;
  localparam int SLOT_CH5_LOWER = 4;

  localparam logic [5:0] REG_INDEX [REG_COUNT] = '{
    IDX_TRANSIENT_LIMIT_CONFIG, IDX_CH4_CURRENT_UPPER,
    IDX_CH4_CURRENT_LOWER, IDX_CH5_CURRENT_UPPER, IDX_CH5_CURRENT_LOWER};
  localparam logic [7:0] REG_RESET [REG_COUNT] = '{
    RST_TRANSIENT_LIMIT_CONFIG, RST_CH4_CURRENT_UPPER,
    RST_CH4_CURRENT_LOWER, RST_CH5_CURRENT_UPPER, RST_CH5_CURRENT_LOWER};

  // field positions in the wide bit numbering, and each register's base bit
  localparam int LIMIT_BASE_BIT      = 16;
  localparam int THRESHOLD_MSB       = 22;
  localparam int THRESHOLD_LSB       = 19;
  localparam int CH6_ENABLE_BIT      = 18;
  localparam int CH5_ENABLE_BIT      = 17;
  localparam int CH4_ENABLE_BIT      = 16;
  localparam int CH4_UPPER_BASE_BIT  = 24;
  localparam int CH4_CODE_HI_MSB     = 25;
  localparam int CH4_CODE_HI_LSB     = 24;
  localparam int CH4_LOWER_BASE_BIT  = 32;
  localparam int CH5_UPPER_BASE_BIT  = 40;
  localparam int CH5_CODE_HI_MSB     = 41;
  localparam int CH5_CODE_HI_LSB     = 40;
  localparam int CH5_LOWER_BASE_BIT  = 48;

  // code ceilings software is expected to respect
  localparam logic [9:0] CODE_CEILING_FULL    = 10'h307;
  localparam logic [9:0] CODE_CEILING_REDUCED = 10'h0FF;

  // status bit positions in the code status register
  localparam int ST_CH4_ABOVE_FULL    = 0;
  localparam int ST_CH4_ABOVE_REDUCED = 1;
  localparam int ST_CH5_ABOVE_FULL    = 2;
  localparam int ST_CH5_ABOVE_REDUCED = 3;

  // threshold in milliamps for each limit code, ascending
  localparam logic [10:0] THRESHOLD_MA [16] = '{
    11'h082, 11'h096, 11'h0AC, 11'h0C0, 11'h0DC, 11'h113, 11'h14A, 11'h1B8,
    11'h226, 11'h294, 11'h302, 11'h370, 11'h3DE, 11'h488, 11'h532, 11'h5DC};

  typedef enum logic [1:0] {
    ACC_IDLE   = 2'b00,
    ACC_ANSWER = 2'b01
  } access_state_type;

endpackage

// ---- byte_register.sv ----
// one software-writable byte register with a constant reset value
`timescale 1ns/1ps
module byte_register
  import led_limit_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       write_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] value_out
);

  logic [7:0] next_value;

  // hold unless a committed write targets this register
  always_comb begin
    next_value = value_out;
    if (write_in) begin
      next_value = data_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      value_out <= RESET_VALUE;
    end else begin
      value_out <= next_value;
    end
  end

endmodule

// ---- apb_access_ctrl.sv ----
// apb access sequencing: one wait state, then a registered ready
`timescale 1ns/1ps
module apb_access_ctrl
  import led_limit_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic psel_in,
  input  wire logic penable_in,
  output logic      load_out,
  output logic      commit_out,
  output logic      pready_out
);

  access_state_type state;
  access_state_type next_state;

  // first access cycle loads the answer, second completes it
  always_comb begin
    next_state = state;
    load_out   = 1'b0;
    commit_out = 1'b0;
    case (state)
      ACC_IDLE: begin
        if (psel_in && penable_in) begin
          load_out   = 1'b1;
          next_state = ACC_ANSWER;
        end
      end
      ACC_ANSWER: begin
        // ready is high now; the write lands on this edge only
        commit_out = psel_in && penable_in;
        next_state = ACC_IDLE;
      end
      default: begin
        next_state = ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state      <= ACC_IDLE;
      pready_out <= 1'b0;
    end else begin
      state      <= next_state;
      pready_out <= (next_state == ACC_ANSWER);
    end
  end

endmodule

// ---- led_current_limit_regs.sv ----
// apb register slice for led transient limits and channel drive codes
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module led_current_limit_regs
  import led_limit_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic [ADDR_WIDTH-1:0] paddr_in,
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [DATA_WIDTH-1:0] pwdata_in,
  input  wire logic [3:0]            pstrb_in,
  output logic      [DATA_WIDTH-1:0] prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  output logic      [3:0]            limit_threshold_code_out,
  output logic      [MA_WIDTH-1:0]   threshold_ma_out,
  output logic                       ch4_limit_enable_out,
  output logic                       ch5_limit_enable_out,
  output logic                       ch6_limit_enable_out,
  output logic      [CODE_WIDTH-1:0] ch4_drive_code_out,
  output logic      [CODE_WIDTH-1:0] ch5_drive_code_out
);

  logic                   load;
  logic                   commit;
  logic [INDEX_WIDTH-1:0] index;
  logic [REG_WIDTH-1:0]   reg_value [REG_COUNT];
  logic [REG_COUNT-1:0]   reg_hit;
  logic                   status_hit;
  logic                   mapped;
  logic [REG_WIDTH-1:0]   code_status;
  logic [DATA_WIDTH-1:0]  read_word;
  logic [DATA_WIDTH-1:0]  next_prdata;
  logic                   next_pslverr;

  logic [3:0]             next_threshold;
  logic [MA_WIDTH-1:0]    next_threshold_ma;
  logic                   next_ch4_enable;
  logic                   next_ch5_enable;
  logic                   next_ch6_enable;
  logic [CODE_WIDTH-1:0]  next_ch4_code;
  logic [CODE_WIDTH-1:0]  next_ch5_code;

  // byte addresses hold one register per aligned word
  assign index = paddr_in[ADDR_WIDTH-1:2];

  apb_access_ctrl access (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .psel_in    (psel_in),
    .penable_in (penable_in),
    .load_out   (load),
    .commit_out (commit),
    .pready_out (pready_out)
  );

  // writable bank; only byte lane zero carries data
  genvar i;
  generate
    for (i = 0; i < REG_COUNT; i = i + 1) begin : bank
      assign reg_hit[i] = (index == REG_INDEX[i]);
      byte_register #(
        .RESET_VALUE (REG_RESET[i])
      ) storage (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .write_in   (commit && pwrite_in && pstrb_in[0] && reg_hit[i]),
        .data_in    (pwdata_in[REG_WIDTH-1:0]),
        .value_out  (reg_value[i])
      );
    end
  endgenerate

  // read-only views of the block's own state
  assign status_hit = (index == IDX_CODE_STATUS) ||
                      (index == IDX_THRESHOLD_MA);
  assign mapped     = (|reg_hit) || status_hit;

  // flags when a programmed code passes a ceiling software should keep
  always_comb begin
    code_status = '0;
    code_status[ST_CH4_ABOVE_FULL]    = ch4_drive_code_out > CODE_CEILING_FULL;
    code_status[ST_CH5_ABOVE_FULL]    = ch5_drive_code_out > CODE_CEILING_FULL;
    code_status[ST_CH4_ABOVE_REDUCED] =
      ch4_drive_code_out > CODE_CEILING_REDUCED;
    code_status[ST_CH5_ABOVE_REDUCED] =
      ch5_drive_code_out > CODE_CEILING_REDUCED;
  end

  // read mux; bits 31 down to 11 of every word read zero
  always_comb begin
    read_word = '0;
    for (int k = 0; k < REG_COUNT; k++) begin
      if (reg_hit[k]) begin
        read_word[REG_WIDTH-1:0] = reg_value[k];
      end
    end
    if (index == IDX_CODE_STATUS) begin
      read_word[REG_WIDTH-1:0] = code_status;
    end
    if (index == IDX_THRESHOLD_MA) begin
      read_word[MA_WIDTH-1:0] = threshold_ma_out;
    end
  end

  // answer is captured in the wait cycle and stands only with ready
  // unmapped, or a write to a read-only view, answers with an error
  always_comb begin
    next_prdata  = '0;
    next_pslverr = 1'b0;
    if (load) begin
      next_pslverr = !mapped || (pwrite_in && status_hit);
      next_prdata  = (pwrite_in || !mapped) ? '0 : read_word;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_out  <= '0;
      pslverr_out <= 1'b0;
    end else begin
      prdata_out  <= next_prdata;
      pslverr_out <= next_pslverr;
    end
  end

  // fields picked out of the stored bytes for the analog driver
  always_comb begin
    next_threshold = reg_value[SLOT_LIMIT]
      [THRESHOLD_MSB-LIMIT_BASE_BIT:THRESHOLD_LSB-LIMIT_BASE_BIT];
    next_threshold_ma = THRESHOLD_MA[next_threshold];
    next_ch6_enable = reg_value[SLOT_LIMIT][CH6_ENABLE_BIT-LIMIT_BASE_BIT];
    next_ch5_enable = reg_value[SLOT_LIMIT][CH5_ENABLE_BIT-LIMIT_BASE_BIT];
    next_ch4_enable = reg_value[SLOT_LIMIT][CH4_ENABLE_BIT-LIMIT_BASE_BIT];
    next_ch4_code = {reg_value[SLOT_CH4_UPPER]
      [CH4_CODE_HI_MSB-CH4_UPPER_BASE_BIT:CH4_CODE_HI_LSB-CH4_UPPER_BASE_BIT],
      reg_value[SLOT_CH4_LOWER]};
    next_ch5_code = {reg_value[SLOT_CH5_UPPER]
      [CH5_CODE_HI_MSB-CH5_UPPER_BASE_BIT:CH5_CODE_HI_LSB-CH5_UPPER_BASE_BIT],
      reg_value[SLOT_CH5_LOWER]};
  end

  // driver outputs
  // a one-cycle lag keeps every driver output straight off a flop
  // code passed unaltered, so current stays monotonic
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      limit_threshold_code_out <= RST_TRANSIENT_LIMIT_CONFIG[6:3];
      threshold_ma_out         <=
        THRESHOLD_MA[RST_TRANSIENT_LIMIT_CONFIG[6:3]];
      ch4_limit_enable_out     <= 1'b0;
      ch5_limit_enable_out     <= 1'b0;
      ch6_limit_enable_out     <= 1'b0;
      ch4_drive_code_out       <= '0;
      ch5_drive_code_out       <= '0;
    end else begin
      limit_threshold_code_out <= next_threshold;
      threshold_ma_out         <= next_threshold_ma;
      ch4_limit_enable_out     <= next_ch4_enable;
      ch5_limit_enable_out     <= next_ch5_enable;
      ch6_limit_enable_out     <= next_ch6_enable;
      ch4_drive_code_out       <= next_ch4_code;
      ch5_drive_code_out       <= next_ch5_code;
    end
  end

endmodule

// ---- led_limit_asserts.sv ----
// port assertions for the led current-limit register slice
`timescale 1ns/1ps
module led_limit_asserts
  import led_limit_pkg::*;
(
  input wire logic                  clk_in,
  input wire logic                  reset_n_in,
  input wire logic [ADDR_WIDTH-1:0] paddr_in,
  input wire logic                  psel_in,
  input wire logic                  penable_in,
  input wire logic                  pwrite_in,
  input wire logic [DATA_WIDTH-1:0] pwdata_in,
  input wire logic [3:0]            pstrb_in,
  input wire logic [DATA_WIDTH-1:0] prdata_out,
  input wire logic                  pready_out,
  input wire logic                  pslverr_out,
  input wire logic [3:0]            limit_threshold_code_out,
  input wire logic [MA_WIDTH-1:0]   threshold_ma_out,
  input wire logic                  ch4_limit_enable_out,
  input wire logic                  ch5_limit_enable_out,
  input wire logic                  ch6_limit_enable_out,
  input wire logic [CODE_WIDTH-1:0] ch4_drive_code_out,
  input wire logic [CODE_WIDTH-1:0] ch5_drive_code_out
);
  // completed write with the low byte strobed, and its register index
  wire logic       wr  = pready_out && psel_in && penable_in && pwrite_in
                         && pstrb_in[0];
  wire logic [5:0] idx = paddr_in[7:2];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // one wait state, then a single ready pulse
  ready_wait_a: assert property (
    $rose(penable_in) && psel_in
    |-> !pready_out ##1 pready_out ##1 !pready_out)
    else $error("ready not two cycles after setup");
  ready_cause_a: assert property (
    pready_out |-> $past(psel_in && penable_in))
    else $error("ready without an access");
  // read data is only driven with ready, bits 31 down to 11 always zero
  rdata_idle_a: assert property (
    prdata_out[31:MA_WIDTH] == 21'h0 &&
    (pready_out || (prdata_out == 32'h0 && !pslverr_out)))
    else $error("read data not quiet");
  unmapped_err_a: assert property (
    pready_out && !(idx inside {[6'h02:6'h06], 6'h30, 6'h31}) |-> pslverr_out)
    else $error("unmapped index not refused");
  // store lands at the ready edge, driver outputs one edge after that
  limit_field_a: assert property (
    wr && idx == IDX_TRANSIENT_LIMIT_CONFIG |-> ##2 {limit_threshold_code_out,
    ch6_limit_enable_out, ch5_limit_enable_out, ch4_limit_enable_out}
    == $past(pwdata_in[6:0], 2)) else $error("limit fields not applied");
  ch4_upper_a: assert property (
    wr && idx == IDX_CH4_CURRENT_UPPER
    |-> ##2 ch4_drive_code_out[9:8] == $past(pwdata_in[1:0], 2))
    else $error("channel four high code bits not applied");
  ch4_lower_a: assert property (
    wr && idx == IDX_CH4_CURRENT_LOWER
    |-> ##2 ch4_drive_code_out[7:0] == $past(pwdata_in[7:0], 2))
    else $error("channel four low code byte not applied");
  ch5_upper_a: assert property (
    wr && idx == IDX_CH5_CURRENT_UPPER
    |-> ##2 ch5_drive_code_out[9:8] == $past(pwdata_in[1:0], 2))
    else $error("channel five high code bits not applied");
  ch5_lower_a: assert property (
    wr && idx == IDX_CH5_CURRENT_LOWER
    |-> ##2 ch5_drive_code_out[7:0] == $past(pwdata_in[7:0], 2))
    else $error("channel five low code byte not applied");
  // both drive codes hold unless a write completed two edges earlier
  codes_hold_a: assert property (
    !$past(wr) |=> $stable(ch4_drive_code_out) && $stable(ch5_drive_code_out))
    else $error("drive code moved without a write");
endmodule

// ---- tb_led_current_limit_regs.sv ----
// self-checking bench for the led current-limit register slice
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  failures++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb_led_current_limit_regs
  import led_limit_pkg::*;
;
  logic        clk_in = 0, reset_n_in = 0, psel_in = 0, penable_in = 0;
  logic        pwrite_in = 0, pready_out, pslverr_out, er;
  logic        ch4_limit_enable_out, ch5_limit_enable_out;
  logic        ch6_limit_enable_out;
  logic [7:0]  paddr_in = 0, m [7];
  logic [3:0]  pstrb_in = 0, limit_threshold_code_out;
  logic [31:0] pwdata_in = 0, prdata_out, rd;
  logic [10:0] threshold_ma_out;
  logic [9:0]  ch4_drive_code_out, ch5_drive_code_out;
  int          failures = 0, num_checks = 0, k;
  int ma_tab [16] = '{130, 150, 172, 192, 220, 275, 330, 440, 550, 660, 770,
                      880, 990, 1160, 1330, 1500};
  // 10 MHz clock
  always #50 clk_in = ~clk_in;
  led_current_limit_regs DUT (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .threshold_ma_out(threshold_ma_out),
    .limit_threshold_code_out(limit_threshold_code_out),
    .ch4_limit_enable_out(ch4_limit_enable_out),
    .ch5_limit_enable_out(ch5_limit_enable_out),
    .ch6_limit_enable_out(ch6_limit_enable_out),
    .ch4_drive_code_out(ch4_drive_code_out),
    .ch5_drive_code_out(ch5_drive_code_out));
  task conclude;
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one apb transfer; the answer is taken only at the ready edge
  task apb(input logic w, input logic [7:0] a, d, input logic [3:0] s);
    int n;
    @(posedge clk_in);
    psel_in <= 1; penable_in <= 0; paddr_in <= a; pwrite_in <= w;
    pwdata_in <= {24'($urandom), d}; pstrb_in <= s;
    @(posedge clk_in);
    penable_in <= 1;
    n = 0;
    do begin @(posedge clk_in); n++; end while (pready_out !== 1'b1 && n < 8);
    if (pready_out !== 1'b1) begin failures++; conclude(); end
    rd = prdata_out; er = pslverr_out;
    psel_in <= 0; penable_in <= 0;
  endtask
  // write a byte register; outputs settle one edge after the store
  task wr(input int i, input logic [7:0] d);
    m[i] = d;
    apb(1, 8'(i * 4), d, {3'($urandom), 1'b1});
    `CHK("write error", 1'b0, er)
    @(posedge clk_in); #1;
  endtask
  task rchk(input int i);
    apb(0, 8'(i * 4), 8'h00, 4'h0);
    `CHK("readback", {24'h0, m[i]}, rd)
    `CHK("read error", 1'b0, er)
  endtask
  function logic [9:0] code(input int u);
    code = {m[u][1:0], m[u + 1]};
  endfunction
  task outs;
    `CHK("threshold", m[2][6:3], limit_threshold_code_out)
    `CHK("milliamps", 11'(ma_tab[m[2][6:3]]), threshold_ma_out)
    `CHK("enables", m[2][2:0], {ch6_limit_enable_out, ch5_limit_enable_out,
         ch4_limit_enable_out})
    `CHK("ch4 code", code(3), ch4_drive_code_out)
    `CHK("ch5 code", code(5), ch5_drive_code_out)
    apb(0, 8'hC0, 8'h00, 4'h0);
    `CHK("status", {28'h0, code(5) > 10'h0FF, code(5) > 10'h307,
         code(3) > 10'h0FF, code(3) > 10'h307}, rd)
  endtask
  // reset values of the model, then a checked reset sequence
  task reset_all;
    foreach (m[i]) m[i] = 8'h00;
    m[2] = 8'h30;
    reset_n_in <= 0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1;
    #1 outs;
    for (int i = 2; i < 7; i++) rchk(i);
  endtask
  initial begin
    void'($urandom(30734));
    reset_all;
    // every threshold code with random enables and spare bit
    for (int i = 0; i < 16; i++) begin
      k = $urandom;
      wr(2, {k[7], 4'(i), k[2:0]});
      outs;
      rchk(2);
    end
    // ceiling corners
    // code ceilings at and just above the boundaries
    wr(3, 8'hFF); wr(4, 8'h07); outs;
    wr(4, 8'h08); wr(5, 8'h00); wr(6, 8'hFF); outs;
    wr(5, 8'h01); wr(6, 8'h00); outs;
    repeat (24) begin
      k = 3 + $urandom % 4;
      wr(k, 8'($urandom));
      outs;
      rchk(k);
    end
    // unmapped read, read-only write, unstrobed write
    apb(0, 8'h1C, 8'h00, 4'h0);
    `CHK("unmapped error", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    apb(1, 8'hC0, 8'hFF, 4'h1);
    `CHK("read-only error", 1'b1, er)
    apb(1, 8'h10, ~m[4], 4'hE);
    @(posedge clk_in); #1 outs;
    reset_all;
    conclude;
  end
endmodule
bind led_current_limit_regs led_limit_asserts chk (.clk_in(clk_in),
  .reset_n_in(reset_n_in), .paddr_in(paddr_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
  .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .threshold_ma_out(threshold_ma_out),
  .limit_threshold_code_out(limit_threshold_code_out),
  .ch4_limit_enable_out(ch4_limit_enable_out),
  .ch5_limit_enable_out(ch5_limit_enable_out),
  .ch6_limit_enable_out(ch6_limit_enable_out),
  .ch4_drive_code_out(ch4_drive_code_out),
  .ch5_drive_code_out(ch5_drive_code_out));
